// >>> csrf_clock_guard.sv
// clock source selection, clock guard and reset flag register
`timescale 1ns/1ns
`default_nettype none

module csrf_clock_guard
  import csrf_pkg::*;
#(
  parameter int SPIKE_CYC = SPIKE_MIN_CYC,
  parameter int BACKUP_HALF = BACKUP_HALF_CYC,
  parameter int RECOVER_N = RECOVER_EDGES
)
(
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire csrf_apb_req_t I_APB,
  output var csrf_apb_rsp_t O_APB,
  input wire logic [2:0] I_OSC_MODE,
  input wire logic I_GUARD_OPT_EN,
  input wire logic I_OSC_IN_PIN,
  input wire logic I_INT_RC_CLK,
  input wire logic I_LVD_RST,
  input wire logic I_WDG_RST_EVT,
  input wire logic I_HALT,
  input wire logic I_ACTIVE_HALT,
  input wire logic I_WAIT,
  input wire logic I_IRQ_MASK,
  input wire logic I_TIMEBASE_IRQ,
  output logic O_CORE_CLK,
  output logic O_ON_BACKUP,
  output logic O_OSC_OUT_EN,
  output logic O_SHARED_IRQ,
  output logic O_WAKE
);

  localparam logic [CNT_W-1:0] SPIKE_LIM = CNT_W'(SPIKE_CYC - 1);
  localparam logic [CNT_W-1:0] LOST_LIM = CNT_W'(2 * BACKUP_HALF - 1);
  localparam logic [CNT_W-1:0] BK_LIM = CNT_W'(BACKUP_HALF - 1);
  localparam logic [CNT_W-1:0] GOOD_LIM = CNT_W'(RECOVER_N - 1);
  localparam logic [CNT_W-1:0] CNT_SAT = {CNT_W{1'b1}};

  // pin synchronisers: a new level counts once stages two and three agree
  wire [1:0] pins = {I_INT_RC_CLK, I_OSC_IN_PIN};
  wire [1:0] pin_lvl;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      always_ff @(posedge I_REF_CLK or posedge I_RST)
      begin
        if (I_RST)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          lvl <= 1'b0;
        end
        else if (I_CE)
        begin
          s1 <= pins[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            lvl <= s3;
        end
      end
      assign pin_lvl[g] = lvl;
    end
  endgenerate

  // mode decode
  wire csrf_osc_mode_t osc_mode = csrf_osc_mode_t'(I_OSC_MODE);
  wire is_res = (osc_mode == OSC_RES0) || (osc_mode == OSC_RES1) ||
                (osc_mode == OSC_RES2) || (osc_mode == OSC_RES3);
  wire drives_pin = is_res || (osc_mode == OSC_EXT_RC);
  wire full_halt = I_HALT && !I_ACTIVE_HALT;
  wire guard_active = I_GUARD_OPT_EN && !full_halt;

  wire main_raw = (osc_mode == OSC_INT_RC) ? pin_lvl[1] : pin_lvl[0];

  logic main_prev;
  logic [CNT_W-1:0] half_cnt;
  logic [CNT_W-1:0] good_cnt;
  logic [CNT_W-1:0] idle_cnt;
  logic filtered;
  logic [CNT_W-1:0] bk_cnt;
  logic bk_lvl;
  logic sel_bk;
  logic core_clk;
  logic in_reset;
  logic osc_en;
  csrf_guard_st_t state;
  csrf_guard_st_t next_state;

  wire main_edge = main_raw != main_prev;
  wire spike = main_edge && (half_cnt < SPIKE_LIM);
  wire good_edge = main_edge && !spike;
  wire next_filtered = spike || (filtered && !(good_edge && good_cnt >= GOOD_LIM));
  wire lost = idle_cnt >= LOST_LIM;
  wire healthy = !filtered && !lost;
  wire main_out = I_GUARD_OPT_EN ? (main_prev && !filtered) : main_prev;

  // edge timing and filter state; frozen in halt
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      main_prev <= 1'b0;
      half_cnt <= '0;
      good_cnt <= '0;
      idle_cnt <= '0;
      filtered <= 1'b0;
    end
    else if (I_CE && guard_active)
    begin
      main_prev <= main_raw;
      half_cnt <= main_edge ? '0 : ((half_cnt == CNT_SAT) ? half_cnt : half_cnt + 1'b1);
      good_cnt <= spike ? '0 : ((good_edge && good_cnt != CNT_SAT) ? good_cnt + 1'b1 : good_cnt);
      idle_cnt <= good_edge ? '0 : ((idle_cnt == CNT_SAT) ? idle_cnt : idle_cnt + 1'b1);
      filtered <= next_filtered;
    end
    else if (I_CE && !full_halt)
      main_prev <= main_raw;
  end

  always_comb
  begin
    next_state = state;
    if (!guard_active)
      next_state = ST_OFF;
    else
    begin
      case (state)
        ST_OFF: next_state = ST_MAIN;
        ST_MAIN: next_state = lost ? ST_BACKUP : ST_MAIN;
        ST_BACKUP: next_state = healthy ? ST_MAIN : ST_BACKUP;
        default: next_state = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
      state <= ST_OFF;
    else if (I_CE)
      state <= next_state;
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      bk_cnt <= '0;
      bk_lvl <= 1'b0;
    end
    else if (I_CE && guard_active)
    begin
      bk_cnt <= (bk_cnt >= BK_LIM) ? '0 : bk_cnt + 1'b1;
      if (bk_cnt >= BK_LIM)
        bk_lvl <= !bk_lvl;
    end
  end

  // change source only while the new one is low and the old is low or dead
  wire want_bk = state == ST_BACKUP;
  wire new_lvl = want_bk ? bk_lvl : main_out;
  wire may_switch = !new_lvl && (!core_clk || lost);
  wire next_sel = (want_bk != sel_bk && may_switch) ? want_bk : sel_bk;
  wire next_core = full_halt ? 1'b0 : (next_sel ? bk_lvl : main_out);

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      sel_bk <= 1'b0;
      core_clk <= 1'b0;
    end
    else if (I_CE)
    begin
      sel_bk <= next_sel;
      core_clk <= next_core;
    end
  end

  assign O_CORE_CLK = core_clk;
  assign O_ON_BACKUP = sel_bk;

  // oscillator drive survives reset in resonator modes
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
      in_reset <= 1'b1;
    else if (I_CE)
      in_reset <= 1'b0;
  end

  always_ff @(posedge I_REF_CLK or posedge I_LVD_RST)
  begin
    if (I_LVD_RST)
      osc_en <= 1'b0;
    else if (I_CE)
      osc_en <= drives_pin && !full_halt && (is_res || !in_reset);
  end

  assign O_OSC_OUT_EN = osc_en;

  // register bus: one wait state, then the transfer completes
  wire acc = I_APB.psel && I_APB.penable;
  wire hit = I_APB.paddr == CRS_ADDR;
  logic ready;
  wire done = acc && ready;
  wire wr_done = done && I_APB.pwrite && hit && !full_halt;
  wire rd_done = done && !I_APB.pwrite && hit && !full_halt;

  logic lvd_flag;
  logic wdg_flag;
  logic det;
  logic ie;
  // flag reads zero with guard disabled
  wire det_shown = det && I_GUARD_OPT_EN;
  wire [7:0] read_val = CRS_RESET_MASK | {3'h0, lvd_flag, 1'b0, ie, det_shown, wdg_flag};
  wire [31:0] next_rdata = (hit && !I_APB.pwrite) ? {24'h000000, read_val} : 32'h00000000;

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      ready <= 1'b0;
      O_APB <= '0;
    end
    else if (I_CE)
    begin
      ready <= acc && !ready;
      O_APB.pready <= acc && !ready;
      O_APB.pslverr <= acc && !ready && !hit;
      if (acc && !ready)
        O_APB.prdata <= next_rdata;
    end
  end

  // flag set only by low-voltage reset, kept through others
  always_ff @(posedge I_REF_CLK or posedge I_LVD_RST)
  begin
    if (I_LVD_RST)
      lvd_flag <= 1'b1;
    else if (I_CE && wr_done && !I_APB.pwdata[LVD_BIT])
      lvd_flag <= 1'b0;
  end

  // watchdog flag, cleared by low-voltage reset, set wins
  always_ff @(posedge I_REF_CLK or posedge I_LVD_RST)
  begin
    if (I_LVD_RST)
      wdg_flag <= 1'b0;
    else if (I_CE)
    begin
      if (I_WDG_RST_EVT)
        wdg_flag <= 1'b1;
      else if (wr_done && !I_APB.pwdata[WDG_BIT])
        wdg_flag <= 1'b0;
    end
  end

  // detection flag and enable; reset clears, halt wake keeps
  wire det_set = I_GUARD_OPT_EN && state == ST_BACKUP;
  wire det_clr = rd_done && state == ST_MAIN;

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      det <= 1'b0;
      ie <= 1'b0;
    end
    else if (I_CE && !full_halt)
    begin
      if (det_set)
        det <= 1'b1;
      else if (det_clr || !I_GUARD_OPT_EN)
        det <= 1'b0;
      if (wr_done)
        ie <= I_APB.pwdata[IE_BIT];
    end
  end

  // level request while flag, enable and open mask hold
  wire guard_req = det_shown && ie && !I_IRQ_MASK;

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_SHARED_IRQ <= 1'b0;
      O_WAKE <= 1'b0;
    end
    else if (I_CE)
    begin
      O_SHARED_IRQ <= guard_req || I_TIMEBASE_IRQ;
      // wake from wait and active-halt only
      O_WAKE <= guard_req && (I_WAIT || I_ACTIVE_HALT) && !full_halt;
    end
  end

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST || !I_CE);

  sequence s_lost;
    state == ST_MAIN && lost && guard_active;
  endsequence

  sequence s_heal;
    state == ST_BACKUP && healthy && guard_active;
  endsequence

  backup_take_a: assert property (s_lost |=> state == ST_BACKUP || !guard_active)
    else $error("backup not taken after main clock lost");
  main_return_a: assert property (s_heal |=> state != ST_BACKUP)
    else $error("no return to main clock after recovery");
  spike_filter_a: assert property (guard_active && spike |=> filtered)
    else $error("spike did not start filtering");
  det_set_a: assert property (det_set && !full_halt |=> det)
    else $error("detection flag not set on backup");
  det_clear_a: assert property (det_clr && !det_set && next_state == ST_MAIN |=> !det)
    else $error("detection flag not cleared by read");
  det_off_a: assert property (!I_GUARD_OPT_EN |-> !read_val[DET_BIT] && !guard_req)
    else $error("guard disabled but flag or request active");
  irq_gate_a: assert property (O_SHARED_IRQ && !$past(I_TIMEBASE_IRQ) |-> $past(ie) && !$past(I_IRQ_MASK))
    else $error("interrupt without enable or with mask set");
  irq_hold_a: assert property (guard_req [*2] |-> O_SHARED_IRQ)
    else $error("interrupt request dropped while flag and enable set");
  halt_freeze_a: assert property (full_halt ##1 full_halt |-> $stable(det) && $stable(ie))
    else $error("register changed during halt");
  halt_wake_a: assert property (full_halt |=> !O_WAKE)
    else $error("guard interrupt woke device from halt");
  wait_wake_a: assert property (guard_req && I_WAIT && !full_halt |=> O_WAKE)
    else $error("guard interrupt did not wake from wait");
  wdg_set_a: assert property (I_WDG_RST_EVT && !I_LVD_RST |=> wdg_flag)
    else $error("watchdog flag not set");
  osc_keep_a: assert property (is_res && !full_halt && !I_LVD_RST |=> osc_en)
    else $error("resonator drive dropped");

endmodule : csrf_clock_guard

`default_nettype wire

// >>> csrf_pkg.sv
// shared constants and types for the clock guard and reset flag block
package csrf_pkg;

  // register index as mapped; byte address is four times the index
  localparam logic [11:0] CRS_IDX = 12'h02b;
  localparam logic [11:0] CRS_ADDR = 12'(CRS_IDX * 4);

  // field positions in clock_reset_status
  localparam int WDG_BIT = 0;
  localparam int DET_BIT = 1;
  localparam int IE_BIT = 2;
  localparam int LVD_BIT = 4;
  localparam logic [7:0] CRS_RESET_MASK = 8'h00;

  // reference clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SPIKE_MIN_NS = 200;
  localparam int SPIKE_MIN_CYC_RAW = (SPIKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPIKE_MIN_CYC = (SPIKE_MIN_CYC_RAW < 1) ? 1 : SPIKE_MIN_CYC_RAW;
  localparam int BACKUP_PERIOD_NS = 3200;
  localparam int BACKUP_HALF_RAW = BACKUP_PERIOD_NS / CLK_PERIOD_NS / 2;
  localparam int BACKUP_HALF_CYC = (BACKUP_HALF_RAW < 1) ? 1 : BACKUP_HALF_RAW;
  localparam int BACKUP_PERIOD_CYC = 2 * BACKUP_HALF_CYC;
  localparam int RECOVER_EDGES = 4;
  localparam int CNT_W = 8;

  // oscillator option encodings
  typedef enum logic [2:0] {
    OSC_EXT_CLK = 3'h0,
    OSC_RES0 = 3'h1,
    OSC_RES1 = 3'h2,
    OSC_RES2 = 3'h3,
    OSC_RES3 = 3'h4,
    OSC_EXT_RC = 3'h5,
    OSC_INT_RC = 3'h6
  } csrf_osc_mode_t;

  // clock guard states, one-hot
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_MAIN = 3'b010,
    ST_BACKUP = 3'b100
  } csrf_guard_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } csrf_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } csrf_apb_rsp_t;

endpackage : csrf_pkg

// >>> csrf_osc_model.sv
// behavioural external clock source on the oscillator input pin
`timescale 1ns/1ns
`default_nettype none

module csrf_osc_model
(
  input wire logic i_run,
  input wire logic [15:0] i_half_ns,
  output logic o_pin
);
  // a stopped source holds its last level, like a broken resonator
  initial
  begin
    o_pin = 1'b0;
    forever
    begin
      if (i_run)
      begin
        #(i_half_ns);
        o_pin = ~o_pin;
      end
      else
        #50;
    end
  end
endmodule : csrf_osc_model

`default_nettype wire

// >>> tb.sv
// self-checking bench for the clock guard and reset flag block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module tb;
  import csrf_pkg::*;
  localparam int BK = 2 * BACKUP_HALF_CYC;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic low_voltage_detector = 1'b1;
  logic wdg = 1'b0;
  logic [2:0] mode = 3'h0;
  logic gen = 1'b1;
  logic halt = 1'b0;
  logic ahalt = 1'b0;
  logic wt = 1'b0;
  logic mask = 1'b1;
  logic tbi = 1'b0;
  logic run = 1'b1;
  logic pin;
  logic core_clk, on_bk, osc_en, irq, wake;
  csrf_apb_req_t req = '0;
  csrf_apb_rsp_t rsp;
  int failures = 0;
  int check_count = 0;

  always #50 clk = ~clk;

  csrf_osc_model csrf_osc_model_inst (.i_run(run), .i_half_ns(16'h00c8), .o_pin(pin));

  csrf_clock_guard #(.BACKUP_HALF(BACKUP_HALF_CYC)) csrf_clock_guard_inst (
    .I_REF_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_APB(req), .O_APB(rsp),
    .I_OSC_MODE(mode), .I_GUARD_OPT_EN(gen), .I_OSC_IN_PIN(pin), .I_INT_RC_CLK(1'b0),
    .I_LVD_RST(low_voltage_detector), .I_WDG_RST_EVT(wdg), .I_HALT(halt), .I_ACTIVE_HALT(ahalt),
    .I_WAIT(wt), .I_IRQ_MASK(mask), .I_TIMEBASE_IRQ(tbi), .O_CORE_CLK(core_clk),
    .O_ON_BACKUP(on_bk), .O_OSC_OUT_EN(osc_en), .O_SHARED_IRQ(irq), .O_WAKE(wake));

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic ncyc(input int n);
    repeat (n) @(posedge clk);
  endtask : ncyc

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] rd,
    output logic err);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h000000, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    // no cycle count assumed; the watchdog ends a hung transfer
    do
    begin
      @(posedge clk);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic wr(input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, CRS_ADDR, d, rd, err);
  endtask : wr

  task automatic rdchk(input logic [7:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, CRS_ADDR, 8'h00, rd, err);
    `CHK("status", {24'h000000, exp}, rd) // register value
    `CHK("slverr", 1'b0, err) // mapped offset
  endtask : rdchk

  task automatic do_rst(input logic lv);
    rst <= 1'b1;
    low_voltage_detector <= lv;
    ncyc(2);
    rst <= 1'b0;
    low_voltage_detector <= 1'b0;
    @(posedge clk);
  endtask : do_rst

  task automatic wait_bk(input logic v);
    int n;
    n = 0;
    while (on_bk !== v && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("on_backup", v, on_bk)
  endtask : wait_bk

  task automatic t_flags;
    logic [31:0] rd;
    logic err;
    rdchk(8'h10);
    wr(8'h00);
    rdchk(8'h00);
    wdg <= 1'b1;
    @(posedge clk);
    wdg <= 1'b0;
    rdchk(8'h01);
    wr(8'h05);
    rdchk(8'h05);
    do_rst(1'b0);
    rdchk(8'h01);
    do_rst(1'b1);
    rdchk(8'h10);
    apb(1'b1, 12'h0b0, 8'h00, rd, err);
    `CHK("bad_err", 1'b1, err)
    apb(1'b0, 12'h0b0, 8'h00, rd, err);
    `CHK("bad_data", 32'h00000000, rd)
    rdchk(8'h10);
  endtask : t_flags

  task automatic t_modes;
    for (int m = 0; m < 7; m++)
    begin
      mode <= 3'(m);
      rst <= 1'b1;
      ncyc(3);
      `CHK("drive_in_reset", (m >= 1 && m <= 4), osc_en)
      rst <= 1'b0;
      ncyc(3);
      `CHK("drive_run", (m >= 1 && m <= 5), osc_en)
    end
    mode <= 3'h0;
    do_rst(1'b0);
  endtask : t_modes

  task automatic t_loss;
    mask <= 1'b0;
    wr(8'h14);
    run <= 1'b0;
    ncyc(BK - 6);
    `CHK("early_backup", 1'b0, on_bk)
    wait_bk(1'b1);
    ncyc(2);
    `CHK("irq", 1'b1, irq)
    wt <= 1'b1;
    ncyc(2);
    `CHK("wake_wait", 1'b1, wake)
    wt <= 1'b0;
    mask <= 1'b1;
    ncyc(2);
    `CHK("irq_masked", 1'b0, irq)
    tbi <= 1'b1;
    ncyc(2);
    `CHK("irq_shared", 1'b1, irq)
    tbi <= 1'b0;
    mask <= 1'b0;
    rdchk(8'h16);
    rdchk(8'h16);
    halt <= 1'b1;
    ahalt <= 1'b1;
    ncyc(2);
    `CHK("wake_ahalt", 1'b1, wake)
    ahalt <= 1'b0;
    ncyc(2);
    `CHK("wake_halt", 1'b0, wake)
    wr(8'h00);
    halt <= 1'b0;
    run <= 1'b1;
    // the loss count was frozen in halt, so the guard may briefly pick backup again
    ncyc(3 * BK);
    wait_bk(1'b0);
    ncyc(2);
    rdchk(8'h16);
    rdchk(8'h14);
    ncyc(2);
    `CHK("irq_clear", 1'b0, irq)
  endtask : t_loss

  task automatic t_off;
    gen <= 1'b0;
    do_rst(1'b0);
    wr(8'h14);
    run <= 1'b0;
    ncyc(BK + 20);
    `CHK("off_backup", 1'b0, on_bk)
    `CHK("off_irq", 1'b0, irq)
    rdchk(8'h14);
    run <= 1'b1;
  endtask : t_off

  initial
  begin
    ncyc(6);
    rst <= 1'b0;
    low_voltage_detector <= 1'b0;
    t_flags();
    t_modes();
    t_loss();
    t_off();
    final_report();
  end

  // run limit well above the expected length of all scenarios
  initial
  begin
    #2000000;
    failures++;
    final_report();
  end
endmodule : tb

`default_nettype wire
